// >>> verilog/dds_core.sv
// dds core: wishbone registers, update clock, accumulator, cosine stage, dac fifo
//
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/1ns

// sample fifo between the cosine stage and the dac
module dds_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady,
    output logic [$clog2(DEPTH):0] level
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
    logic [PW:0] count_reg, count_next;
    logic push, pop;

    // pointer and level bookkeeping
    always_comb begin
        push = inValid && inReady;
        pop = outValid && outReady;
        wrPtr_next = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
        rdPtr_next = pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
        count_next = count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
        end
    end

    // storage has no reset, only written entries are ever read
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    assign inReady = count_reg != (PW+1)'(DEPTH);
    assign outValid = count_reg != '0;
    assign outData = mem[rdPtr_reg];
    assign level = count_reg;
endmodule

// Contract
// - each sample clock the tuning word is added to a 48-bit accumulator; here the accumulator holds while the dac fifo is full
// - output frequency is tuning word times sample rate over two to the 48
// - a programmable phase offset is added to every accumulator phase sample
// - offset phase maps to amplitude as cosine, full scale is one turn
// - one 14-bit amplitude word per sample goes to the dac
// - rf divider ratio 1, 2, 4 or 8 chosen by a control field
// - divided or undivided rf input may clock the core, other drives output
// - reference and feedback dividers take any ratio from 1 to 16
// - three-bit field scales charge pump base current by 1 to 8
// - a control bit engages the crystal oscillator on the reference input
// - driver source is rf input, rf divider output or feedback input
// - a control bit selects the on-chip driver current resistor
// - bits add rising or falling surge current and drop the default surge
// - written values wait for update high, then move on update clock edge
// - update clock is the sample clock divided by four
module dds_core (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [dds_pkg::WB_AW-1:0] wbAdr,
    input wire logic [31:0] wbDatIn,
    output logic [31:0] wbDatOut,
    input wire logic [3:0] wbSel,
    input wire logic wbWe,
    input wire logic wbCyc,
    input wire logic wbStb,
    output logic wbAck,
    input wire logic ioUpdate,
    output logic updateClk,
    output logic [dds_pkg::DAC_W-1:0] dacWord,
    output logic dacValid,
    input wire logic dacReady,
    output logic [1:0] rfDivRatio,
    output logic coreClkUndivided,
    output dds_pkg::dds_drv_src_t drvSource,
    output logic [2:0] pumpScale,
    output logic [3:0] refDivRatio,
    output logic [3:0] fbDivRatio,
    output logic xtalOscEnable,
    output logic drvInternalRes,
    output logic riseSurgeExtra,
    output logic fallSurgeExtra,
    output logic defaultSurgeOff
);
    import dds_pkg::*;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    dds_cfg_t shadow_reg, shadow_next, active_reg, active_next;
    logic [31:0] rdData_reg, rdData_next;
    logic ack_reg, ack_next;
    logic updMeta_reg, updSync_reg;
    logic [1:0] updPhase_reg, updPhase_next;
    logic updateTick;
    logic [ACC_W-1:0] acc_reg, acc_next;
    logic [PHASE_W-1:0] phase_reg, phase_next;
    logic [DAC_W-1:0] amp_reg, amp_next;
    logic v1_reg, v1_next, v2_reg, v2_next;
    logic fifoInReady, advance;
    logic [$clog2(FIFO_DEPTH):0] fifoLevel;
    logic wbWrite;

    function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wr,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = wr[8*b +: 8];
            end
        end
        return res;
    endfunction

    // wishbone slave: one wait state, unmapped reads zero, unmapped writes dropped
    always_comb begin
        wbWrite = wbCyc && wbStb && wbWe && !ack_reg;
        ack_next = wbCyc && wbStb && !ack_reg;
        shadow_next = shadow_reg;
        rdData_next = '0;
        unique case (wbAdr)
            OFS_FTW_LO: rdData_next = shadow_reg.freq_tuning_word[31:0];
            OFS_FTW_HI: rdData_next = {16'h0000, shadow_reg.freq_tuning_word[47:32]};
            OFS_PHASE: rdData_next = {18'h00000, shadow_reg.phaseOffset};
            OFS_CTRL: rdData_next = {(32-CTRL_W)'(0), shadow_reg.ctrl};
            OFS_STATUS: rdData_next = {17'h00000, 3'(fifoLevel), updPhase_reg, updSync_reg,
                                       active_reg.ctrl.cpScale, active_reg.ctrl.rfDiv,
                                       active_reg.ctrl.drvSource, fifoInReady, dacValid};
            OFS_ACC_SNAP: rdData_next = acc_reg[47:16];
            default: rdData_next = '0;
        endcase
        if (wbWrite) begin
            unique case (wbAdr)
                OFS_FTW_LO: shadow_next.freq_tuning_word[31:0] = laneMerge(shadow_reg.freq_tuning_word[31:0], wbDatIn,
                                                              wbSel);
                OFS_FTW_HI: shadow_next.freq_tuning_word[47:32] = 16'(laneMerge({16'h0000,
                    shadow_reg.freq_tuning_word[47:32]}, wbDatIn, wbSel));
                OFS_PHASE: shadow_next.phaseOffset = 14'(laneMerge({18'h00000,
                    shadow_reg.phaseOffset}, wbDatIn, wbSel));
                OFS_CTRL: shadow_next.ctrl = CTRL_W'(laneMerge({(32-CTRL_W)'(0),
                    shadow_reg.ctrl}, wbDatIn, wbSel));
                default: shadow_next = shadow_reg;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shadow_reg <= CFG_RESET;
            rdData_reg <= '0;
            ack_reg <= 1'b0;
        end else begin
            shadow_reg <= shadow_next;
            rdData_reg <= rdData_next;
            ack_reg <= ack_next;
        end
    end

    // update pin synchroniser; phase counter runs free from reset, with no defined relation to the pin
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            updMeta_reg <= 1'b0;
            updSync_reg <= 1'b0;
        end else begin
            updMeta_reg <= ioUpdate;
            updSync_reg <= updMeta_reg;
        end
    end

    // divide-by-four update clock and buffered-to-active transfer
    always_comb begin
        updPhase_next = updPhase_reg + 2'd1;
        updateTick = updSync_reg && updPhase_reg == UPD_LAST;
        active_next = updateTick ? shadow_reg : active_reg;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            updPhase_reg <= '0;
            active_reg <= CFG_RESET;
        end else begin
            updPhase_reg <= updPhase_next;
            active_reg <= active_next;
        end
    end

    // synthesis path stalls as a whole when the dac fifo is full
    always_comb begin
        logic [PHASE_W-1:0] cosPhase;
        logic [DAC_W-2:0] t;
        logic [25:0] prod;
        logic [DAC_W-1:0] mag;
        logic [DAC_W-2:0] magSat;
        cosPhase = '0;
        t = '0;
        prod = '0;
        mag = '0;
        magSat = '0;
        advance = fifoInReady;
        // wraps by truncation and keeps running across tuning changes
        acc_next = advance ? acc_reg + active_reg.freq_tuning_word : acc_reg;
        phase_next = advance ? acc_reg[ACC_W-1 -: PHASE_W] + active_reg.phaseOffset
                             : phase_reg;
        // parabolic half-wave of a quarter-shifted phase approximates the cosine
        cosPhase = phase_reg + QUARTER_TURN;
        t = cosPhase[PHASE_W-2:0];
        prod = 26'(t) * 26'(14'h2000 - {1'b0, t});
        mag = 14'(prod >> 11);
        magSat = mag[DAC_W-1] ? MAG_MAX : mag[DAC_W-2:0];
        amp_next = amp_reg;
        if (advance) begin
            amp_next = cosPhase[PHASE_W-1] ? DAC_MID - {1'b0, magSat}
                                           : DAC_MID + {1'b0, magSat};
        end
        v1_next = advance ? 1'b1 : v1_reg;
        v2_next = advance ? v1_reg : v2_reg;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            acc_reg <= '0;
            phase_reg <= '0;
            amp_reg <= DAC_MID;
            v1_reg <= 1'b0;
            v2_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            phase_reg <= phase_next;
            amp_reg <= amp_next;
            v1_reg <= v1_next;
            v2_reg <= v2_next;
        end
    end

    // sixteen-word buffer toward the 14-bit dac
    dds_fifo #(
        .WIDTH(DAC_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .inData(amp_reg),
        .inValid(v2_reg),
        .inReady(fifoInReady),
        .outData(dacWord),
        .outValid(dacValid),
        .outReady(dacReady),
        .level(fifoLevel)
    );

    // active control fields drive the analog blocks
    always_comb begin
        rfDivRatio = active_reg.ctrl.rfDiv;
        coreClkUndivided = active_reg.ctrl.coreUndivided;
        unique case (active_reg.ctrl.drvSource)
            2'd1: drvSource = DRV_FROM_RF_DIV;
            2'd2: drvSource = DRV_FROM_FEEDBACK;
            default: drvSource = DRV_FROM_RF_IN; // code 3 is not a source
        endcase
        pumpScale = active_reg.ctrl.cpScale;
        refDivRatio = active_reg.ctrl.refDiv;
        fbDivRatio = active_reg.ctrl.fbDiv;
        xtalOscEnable = active_reg.ctrl.xtalOscEnable;
        drvInternalRes = active_reg.ctrl.drvInternalRes;
        riseSurgeExtra = active_reg.ctrl.riseSurgeExtra;
        fallSurgeExtra = active_reg.ctrl.fallSurgeExtra;
        defaultSurgeOff = active_reg.ctrl.defaultSurgeOff;
    end

    // rises at the very edge where the active registers load from the buffer
    assign updateClk = ~updPhase_reg[1];
    assign wbAck = ack_reg;
    assign wbDatOut = rdData_reg;

    accStep_a: assert property (advance |=> acc_reg == $past(acc_reg) + $past(active_reg.freq_tuning_word))
        else $error("accumulator did not step by tuning word");
    accHold_a: assert property (!advance |=> $stable(acc_reg))
        else $error("accumulator moved while stalled");
    phaseSum_a: assert property (advance |=> phase_reg ==
        $past(acc_reg[ACC_W-1 -: PHASE_W]) + $past(active_reg.phaseOffset))
        else $error("phase offset not applied");
    cosPeak_a: assert property (advance && v1_reg && phase_reg == 14'h0000 |=> amp_reg == 14'h3fff)
        else $error("cosine at zero phase not full scale");
    cosTrough_a: assert property (advance && v1_reg && phase_reg == 14'h2000 |=> amp_reg == 14'h0001)
        else $error("cosine at half turn not negative full scale");
    dacHold_a: assert property (dacValid && !dacReady |=> dacValid && $stable(dacWord))
        else $error("dac word changed while stalled");
    updMove_a: assert property (updateTick |=> active_reg == $past(shadow_reg))
        else $error("update did not transfer buffered values");
    updWait_a: assert property (!updateTick |=> $stable(rfDivRatio) && $stable(pumpScale))
        else $error("control changed without update");
    divFour_a: assert property (updPhase_reg == 2'd3 |=> updPhase_reg == 2'd0 ##3
        updPhase_reg == 2'd3) else $error("update clock not divide by four");
    ackPulse_a: assert property (wbAck |=> !wbAck)
        else $error("ack held longer than one cycle");
endmodule

// >>> verilog/dds_pkg.sv
// shared constants and carrier types for the dds core and divider control
package dds_pkg;
    localparam int ACC_W = 48;
    localparam int PHASE_W = 14;
    localparam int DAC_W = 14;
    localparam int WB_AW = 8;
    // register byte offsets
    localparam logic [WB_AW-1:0] OFS_FTW_LO = 8'h00;
    localparam logic [WB_AW-1:0] OFS_FTW_HI = 8'h04;
    localparam logic [WB_AW-1:0] OFS_PHASE = 8'h08;
    localparam logic [WB_AW-1:0] OFS_CTRL = 8'h0c;
    localparam logic [WB_AW-1:0] OFS_STATUS = 8'h10;
    localparam logic [WB_AW-1:0] OFS_ACC_SNAP = 8'h14;
    // update clock is the sample clock divided by four
    localparam int UPD_DIV = 4;
    localparam logic [1:0] UPD_LAST = 2'(UPD_DIV - 1);
    // quarter turn of phase, the cosine shift
    localparam logic [PHASE_W-1:0] QUARTER_TURN = 14'h1000;
    localparam logic [DAC_W-1:0] DAC_MID = 14'h2000;
    localparam logic [DAC_W-2:0] MAG_MAX = 13'h1fff;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        DRV_FROM_RF_IN,
        DRV_FROM_RF_DIV,
        DRV_FROM_FEEDBACK
    } dds_drv_src_t;

    // control word, bit 0 upward: rfDiv, coreUndivided, drvSource, cpScale, ...
    typedef struct packed {
        logic defaultSurgeOff;
        logic fallSurgeExtra;
        logic riseSurgeExtra;
        logic drvInternalRes;
        logic xtalOscEnable;
        logic [3:0] fbDiv;
        logic [3:0] refDiv;
        logic [2:0] cpScale;
        logic [1:0] drvSource;
        logic coreUndivided;
        logic [1:0] rfDiv;
    } dds_ctrl_t;

    typedef struct packed {
        logic [ACC_W-1:0] freq_tuning_word;
        logic [PHASE_W-1:0] phaseOffset;
        dds_ctrl_t ctrl;
    } dds_cfg_t;

    localparam dds_cfg_t CFG_RESET = '0;
    localparam int CTRL_W = $bits(dds_ctrl_t);
endpackage

// >>> test/dds_dac_model.sv
// dac stand-in: takes amplitude words when ready, stalls on command
`timescale 1ns/1ns
module dds_dac_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [dds_pkg::DAC_W-1:0] dacWord,
    input wire logic dacValid,
    input wire logic stall,
    output logic dacReady
);
    import dds_pkg::*;
    logic [DAC_W-1:0] words[$];
    // ready drops only when the bench asks for a slow converter
    assign dacReady = ~stall;
    // one word taken per sample on valid and ready, none lost or repeated
    always @(posedge clk_sys) begin
        if (reset_n && dacValid === 1'b1 && dacReady) begin
            words.push_back(dacWord);
        end
    end
endmodule

// >>> test/tb_top.sv
// testbench for the dds core: bus tasks, control, phase and stream scenarios
`timescale 1ns/1ns
module tb_top;
    import dds_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [WB_AW-1:0] wbAdr = '0;
    logic [31:0] wbDatIn = '0;
    logic [31:0] wbDatOut;
    logic [3:0] wbSel = '0;
    logic wbWe = 1'b0;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbAck;
    logic ioUpdate = 1'b0;
    logic updateClk;
    logic [DAC_W-1:0] dacWord;
    logic dacValid;
    logic dacReady;
    logic stall = 1'b0;
    logic [1:0] rfDivRatio;
    logic coreClkUndivided;
    dds_drv_src_t drvSource;
    logic [2:0] pumpScale;
    logic [3:0] refDivRatio;
    logic [3:0] fbDivRatio;
    logic xtalOscEnable, drvInternalRes, riseSurgeExtra, fallSurgeExtra, defaultSurgeOff;
    logic [CTRL_W-1:0] ctrlSeen;
    int mismatches = 0;
    int checkCount = 0;
    int cycles = 0;
    int n;
    logic [31:0] rd;
    dds_ctrl_t c;
    dds_ctrl_t expCtrl;
    logic [DAC_W-1:0] w[$];

    always #5 clk_sys = ~clk_sys;
    // control outputs gathered in control-word order
    assign ctrlSeen = {defaultSurgeOff, fallSurgeExtra, riseSurgeExtra, drvInternalRes,
        xtalOscEnable, fbDivRatio, refDivRatio, pumpScale, drvSource, coreClkUndivided,
        rfDivRatio};

    dds_core u_dds_core (.clk_sys, .reset_n, .wbAdr, .wbDatIn, .wbDatOut, .wbSel, .wbWe,
        .wbCyc, .wbStb, .wbAck, .ioUpdate, .updateClk, .dacWord, .dacValid, .dacReady,
        .rfDivRatio, .coreClkUndivided, .drvSource, .pumpScale, .refDivRatio, .fbDivRatio,
        .xtalOscEnable, .drvInternalRes, .riseSurgeExtra, .fallSurgeExtra, .defaultSurgeOff);
    dds_dac_model u_dds_dac_model (.clk_sys, .reset_n, .dacWord, .dacValid, .stall,
        .dacReady);

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && checkCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // one classic cycle, request held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [WB_AW-1:0] adr, input logic [31:0] dat);
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatIn <= dat;
        wbSel <= 4'hf;
        do @(posedge clk_sys); while (wbAck !== 1'b1);
        rd = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask
    // pin held past a whole update-clock period, so the phase never matters
    task automatic pulse_update();
        @(posedge clk_sys);
        ioUpdate <= 1'b1;
        repeat (8) @(posedge clk_sys);
        ioUpdate <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    // fresh words only: the backlog from before the update is dropped
    task automatic collect(input int cnt);
        repeat (40) @(posedge clk_sys);
        u_dds_dac_model.words.delete();
        while (u_dds_dac_model.words.size() < cnt) @(posedge clk_sys);
        w = u_dds_dac_model.words;
    endtask

    // hang guard far beyond the few hundred cycles the tests need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        check("control outputs", 32'(ctrlSeen), 32'h0);
        for (int k = 0; k < 6; k++) begin
            wb_xfer(1'b0, WB_AW'(k * 4), 32'h0);
            if (k != 4) check("reset readback", rd, 32'h0);
        end
        // update clock rises every fourth sample clock
        while (updateClk !== 1'b1) @(posedge clk_sys);
        n = 0;
        while (updateClk !== 1'b0) begin @(posedge clk_sys); n++; end
        while (updateClk !== 1'b1) begin @(posedge clk_sys); n++; end
        check("update clock period", n, 32'd4);
        wb_xfer(1'b1, 8'h20, 32'hffffffff);
        wb_xfer(1'b0, 8'h20, 32'h0);
        check("unmapped read", rd, 32'h0);
        // accumulator stays at zero: offsets of none, a quarter and a half turn
        for (int k = 0; k < 3; k++) begin
            wb_xfer(1'b1, OFS_PHASE, 32'(k * 32'h1000));
            pulse_update();
            collect(4);
            check("cosine of offset", 32'(w[3]), k == 0 ? 32'h3fff : k == 1 ? 32'h2000 : 32'h1);
        end
        expCtrl = '0;
        for (int k = 0; k < 4; k++) begin
            c = '0;
            c.rfDiv = 2'(k); // sample clock below 400 MHz here, so every ratio is legal
            c.coreUndivided = k[0];
            c.drvSource = 2'(k);
            c.cpScale = 3'(2 * k + 1);
            c.refDiv = 4'(5 * k);
            c.fbDiv = 4'(15 - 5 * k); // detector inputs assumed under 200 MHz
            c.xtalOscEnable = k[0];
            c.drvInternalRes = k[1];
            c.riseSurgeExtra = ~k[0];
            c.fallSurgeExtra = k[1];
            c.defaultSurgeOff = k[0] ^ k[1];
            wb_xfer(1'b1, OFS_CTRL, 32'(c));
            wb_xfer(1'b0, OFS_CTRL, 32'h0);
            check("buffered control", rd, 32'(c));
            check("active before update", 32'(ctrlSeen), 32'(expCtrl));
            pulse_update();
            expCtrl = c;
            // the unused source code falls back to the rf input
            if (k == 3) expCtrl.drvSource = 2'(DRV_FROM_RF_IN);
            check("active control", 32'(ctrlSeen), 32'(expCtrl));
        end
        // quarter turn per sample: tuning word two to the 46
        wb_xfer(1'b1, OFS_PHASE, 32'h0);
        wb_xfer(1'b1, OFS_FTW_LO, 32'h0);
        wb_xfer(1'b1, OFS_FTW_HI, 32'h4000);
        pulse_update();
        repeat (20) @(posedge clk_sys);
        // dac stalls long enough to fill the fifo
        stall <= 1'b1;
        repeat (40) @(posedge clk_sys);
        wb_xfer(1'b0, OFS_STATUS, 32'h0);
        check("fifo full status", {30'h0, rd[1:0]}, 32'h1);
        check("dac valid held", 32'(dacValid), 32'h1);
        u_dds_dac_model.words.delete();
        for (int k = 0; k < 90; k++) begin
            @(posedge clk_sys);
            stall <= (k % 3 == 0);
        end
        w = u_dds_dac_model.words;
        for (int k = 0; k + 4 < w.size(); k++) begin
            check("half turn apart", 32'(w[k]) + 32'(w[k + 2]), 32'd16384);
            check("four sample period", 32'(w[k + 4]), 32'(w[k]));
        end
        wrap_up();
    end
endmodule
